// *** design/pma_top.v ***
// Program memory access unit: read window, table access, row latches and program control.
// How it works
// RL1: Window hit needs EA bit15 and page bit9.
// RL2: Program address is page low byte plus EA.
// RL3: Page bit8 picks lower or upper word.
// RL4: 512 pages; 0x2xx lower, 0x3xx upper words.
// RL5: Upper data half maps onto any page.
// RL6: Window is read only, never writes flash.
// RL7: Upper word reads zero in bits 15:8.
// RL8: Upper access with zero page raises trap.
// RL9: Penalty one for moves, two otherwise.
// RL10: Repeat loop: two at edges, else one.
// RL11: Rows of 64 words, blocks of eight rows.
// RL12: Blocks and rows aligned from address zero.
// RL13: Table writes land in latches, not flash.
// RL14: Latches rewrite freely; row is 64 words, 128 writes.
// RL15: Software fills unused latches with all ones.
// RL16: Table write takes two cycles; commit separately.
// RL17: Low ops bits 15:0, high ops 23:16.
// RL18: Table address is page byte plus EA.
// RL19: Single word programming also supported.
// RL20: Software sets page, loads latches, then starts.
// RL21: Avoid reprogramming without erase.
// RL22: Start bit self-times, stalls, clears itself.
// RL23: Unlock needs 55h then AAh back to back.
`timescale 1ns/1ps
`include "pma_map.vh"
module pma_top #(
  parameter NVM_CYC = `PMA_NVM_CYC
) (
  input wire clk_sys_i,
  input wire resetn_i,
  // Page register writes from the CPU.
  input wire rpag_we_i,
  input wire wpag_we_i,
  input wire tpag_we_i,
  input wire [9:0] pag_d_i,
  // Data-space access.
  input wire ds_rd_i,
  input wire ds_wr_i,
  input wire [15:0] ds_ea_i,
  input wire ds_is_mov_i,
  input wire ds_in_rep_i,
  input wire ds_rep_edge_i,
  // Table access.
  input wire tbl_rd_i,
  input wire tbl_wr_i,
  input wire tbl_high_i,
  input wire tbl_byte_i,
  input wire [15:0] tbl_ea_i,
  input wire [15:0] tbl_d_i,
  // Flash control and key.
  input wire ctl_we_i,
  input wire ctl_start_i,
  input wire ctl_wren_i,
  input wire ctl_erase_i,
  input wire [3:0] ctl_op_i,
  input wire key_we_i,
  input wire [7:0] key_d_i,
  // Program array read data for the address presented.
  input wire [23:0] pm_rdata_i,
  output reg [22:0] pm_raddr_o,
  output reg pm_rd_o,
  output reg [15:0] rd_data_o,
  output reg rd_valid_o,
  output reg [1:0] penalty_o,
  output reg addr_trap_o,
  output reg [9:0] rpag_o,
  output reg [9:0] wpag_o,
  output reg [7:0] tpag_o,
  output reg [23:0] tbl_addr_o,
  output reg tbl_wr_busy_o,
  output reg ctl_start_o,
  output reg ctl_wren_o,
  output reg ctl_erase_o,
  output reg [3:0] ctl_op_o,
  output reg ctl_err_o,
  output reg stall_o,
  output reg nvm_prog_o,
  output reg nvm_erase_o,
  output reg [23:0] nvm_addr_o,
  output reg [23:0] nvm_wdata_o,
  output reg [5:0] nvm_idx_o
);
  // ****************************************************************
  // Address formation
  // ****************************************************************
  wire win_hit = ds_ea_i[`PMA_EA_WIN_BIT] && rpag_o[`PMA_RPAG_MAP_BIT]; // RL1 RL5
  wire [22:0] win_addr = {rpag_o[7:0], ds_ea_i[14:0]}; // RL2 RL4
  wire [23:0] tbl_addr = {tpag_o, tbl_ea_i}; // RL18
  wire [5:0] row_idx = tbl_ea_i[6:1];
  reg wsel_r;
  reg tbl_hi_r;
  reg tbl_byte_r;
  reg tbl_bsel_r;
  reg win_pend_r;
  reg tbl_pend_r;
  wire [23:0] latch_q [0:63];
  reg [1:0] lo_be;
  always @* begin
    lo_be = 2'h3;
    if (tbl_byte_i) begin
      lo_be = tbl_ea_i[0] ? 2'h2 : 2'h1;
    end
  end
  // ****************************************************************
  // Row holding latches
  // ****************************************************************
  reg tbl_wr_ok;
  always @* begin
    // Configuration space is read-only through table writes.
    tbl_wr_ok = tbl_wr_i && !tpag_o[7] && !tbl_wr_busy_o && !stall_o;
  end
  genvar gi;
  generate
    for (gi = 0; gi < `PMA_ROW_WORDS; gi = gi + 1) begin : g_lat
      pma_latch u_lat (
        .clk_sys_i(clk_sys_i),
        .wr_lo_i(tbl_wr_ok && !tbl_high_i && row_idx == gi), // RL13 RL14 RL17
        .wr_hi_i(tbl_wr_ok && tbl_high_i && row_idx == gi), // RL17
        .lo_be_i(lo_be),
        .hi_be_i(!tbl_byte_i || !tbl_ea_i[0]),
        .lo_d_i(lo_be == 2'h2 ? {tbl_d_i[7:0], 8'h00} : tbl_d_i),
        .hi_d_i(tbl_d_i[7:0]),
        .q_o(latch_q[gi])
      );
    end
  endgenerate
  // ****************************************************************
  // Read path, penalties and trap
  // ****************************************************************
  wire trap_now = (ds_rd_i && ds_ea_i[15] && rpag_o == 10'h000) ||
                  (ds_wr_i && ds_ea_i[15] && wpag_o == 10'h000); // RL8
  reg [1:0] pen_nxt;
  always @* begin
    pen_nxt = 2'h0;
    if (ds_rd_i && win_hit) begin
      if (ds_in_rep_i) begin
        pen_nxt = ds_rep_edge_i ? `PMA_PEN_REP_EDGE : `PMA_PEN_REP_MID; // RL10
      end else begin
        pen_nxt = ds_is_mov_i ? `PMA_PEN_MOV : `PMA_PEN_OTHER; // RL9
      end
    end
  end
  reg [15:0] rd_nxt;
  always @* begin
    rd_nxt = 16'h0000;
    if (win_pend_r) begin
      rd_nxt = wsel_r ? {8'h00, pm_rdata_i[23:16]} : pm_rdata_i[15:0]; // RL3 RL7
    end else if (tbl_pend_r) begin
      if (tbl_hi_r) begin
        rd_nxt = (tbl_byte_r && tbl_bsel_r) ? 16'h0000 : {8'h00, pm_rdata_i[23:16]}; // RL7 RL17
      end else if (tbl_byte_r) begin
        rd_nxt = {8'h00, tbl_bsel_r ? pm_rdata_i[15:8] : pm_rdata_i[7:0]};
      end else begin
        rd_nxt = pm_rdata_i[15:0];
      end
    end
  end
  // ****************************************************************
  // Programming sequencer
  // ****************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_ROW = 2'h2;
  reg [1:0] st_r;
  reg [1:0] key_st_r;
  reg [15:0] tmr_r;
  reg [23:0] base_r;
  wire unlocked = key_st_r == 2'h2;
  wire op_ok = ctl_erase_o ? (ctl_op_o == `PMA_OP_PAGE_ERASE) :
               (ctl_op_o == `PMA_OP_ROW || ctl_op_o == `PMA_OP_WORD);
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rpag_o <= `PMA_RPAG_RESET;
      wpag_o <= `PMA_WPAG_RESET;
      tpag_o <= `PMA_TPAG_RESET;
      pm_raddr_o <= 23'h000000;
      pm_rd_o <= 1'b0;
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
      penalty_o <= 2'h0;
      addr_trap_o <= 1'b0;
      tbl_addr_o <= 24'h000000;
      tbl_wr_busy_o <= 1'b0;
      wsel_r <= 1'b0;
      tbl_hi_r <= 1'b0;
      tbl_byte_r <= 1'b0;
      tbl_bsel_r <= 1'b0;
      win_pend_r <= 1'b0;
      tbl_pend_r <= 1'b0;
      ctl_start_o <= 1'b0;
      ctl_wren_o <= 1'b0;
      ctl_erase_o <= 1'b0;
      ctl_op_o <= 4'h0;
      ctl_err_o <= 1'b0;
      stall_o <= 1'b0;
      nvm_prog_o <= 1'b0;
      nvm_erase_o <= 1'b0;
      nvm_addr_o <= 24'h000000;
      nvm_wdata_o <= 24'h000000;
      nvm_idx_o <= 6'h00;
      st_r <= ST_IDLE;
      key_st_r <= 2'h0;
      tmr_r <= 16'h0000;
      base_r <= 24'h000000;
    end else begin
      if (rpag_we_i) begin
        rpag_o <= pag_d_i;
      end
      if (wpag_we_i) begin
        wpag_o <= pag_d_i;
      end
      if (tpag_we_i) begin
        tpag_o <= pag_d_i[7:0];
      end
      // Window writes are never forwarded to the array.
      pm_rd_o <= (ds_rd_i && win_hit) || tbl_rd_i; // RL6
      if (ds_rd_i && win_hit) begin
        pm_raddr_o <= win_addr;
        wsel_r <= rpag_o[`PMA_RPAG_WSEL_BIT];
      end else if (tbl_rd_i) begin
        pm_raddr_o <= tbl_addr[23:1];
      end
      tbl_hi_r <= tbl_high_i;
      tbl_byte_r <= tbl_byte_i;
      tbl_bsel_r <= tbl_ea_i[0];
      win_pend_r <= ds_rd_i && win_hit;
      tbl_pend_r <= tbl_rd_i && !(ds_rd_i && win_hit);
      rd_valid_o <= win_pend_r || tbl_pend_r;
      rd_data_o <= rd_nxt;
      penalty_o <= pen_nxt;
      addr_trap_o <= trap_now;
      if (tbl_rd_i || tbl_wr_i) begin
        tbl_addr_o <= tbl_addr;
      end
      // Second cycle of a latch write.
      tbl_wr_busy_o <= tbl_wr_ok; // RL16
      if (tbl_wr_ok) begin
        base_r <= tbl_addr;
      end
      // Key must be the two values on consecutive key writes.
      if (key_we_i) begin
        if (key_d_i == `PMA_KEY1) begin
          key_st_r <= 2'h1;
        end else if (key_d_i == `PMA_KEY2 && key_st_r == 2'h1) begin
          key_st_r <= 2'h2;
        end else begin
          key_st_r <= 2'h0;
        end
      end else if (ctl_we_i || tbl_wr_i) begin
        key_st_r <= 2'h0; // RL23
      end
      nvm_prog_o <= 1'b0;
      nvm_erase_o <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (ctl_we_i) begin
            ctl_wren_o <= ctl_wren_i;
            ctl_erase_o <= ctl_erase_i;
            ctl_op_o <= ctl_op_i;
            if (ctl_start_i) begin
              key_st_r <= 2'h0;
              if (ctl_wren_o && unlocked && op_ok) begin
                ctl_start_o <= 1'b1; // RL22
                ctl_err_o <= 1'b0;
                stall_o <= 1'b1;
                tmr_r <= NVM_CYC[15:0];
                nvm_idx_o <= 6'h00;
                if (ctl_erase_o) begin
                  // Block base aligned to 512 words from address zero.
                  nvm_addr_o <= {base_r[23:10], 10'h000}; // RL11 RL12
                  nvm_erase_o <= 1'b1;
                  st_r <= ST_RUN;
                end else if (ctl_op_o == `PMA_OP_WORD) begin
                  nvm_addr_o <= base_r; // RL19
                  nvm_idx_o <= base_r[6:1];
                  nvm_wdata_o <= latch_q[base_r[6:1]];
                  nvm_prog_o <= 1'b1;
                  st_r <= ST_RUN;
                end else begin
                  nvm_addr_o <= {base_r[23:7], 7'h00}; // RL11 RL12
                  nvm_wdata_o <= latch_q[0];
                  nvm_prog_o <= 1'b1;
                  st_r <= ST_ROW;
                end
              end else begin
                ctl_err_o <= 1'b1;
              end
            end
          end
        end
        ST_ROW: begin
          // Stream all 64 latches out, then wait out the timed cycle.
          if (nvm_idx_o == 6'h3f) begin
            st_r <= ST_RUN;
          end else begin
            nvm_idx_o <= nvm_idx_o + 6'h01;
            nvm_wdata_o <= latch_q[nvm_idx_o + 6'h01];
            nvm_addr_o <= nvm_addr_o + 24'h000002;
            nvm_prog_o <= 1'b1;
          end
        end
        ST_RUN: begin
          if (tmr_r <= 16'h0001) begin
            ctl_start_o <= 1'b0; // RL22
            stall_o <= 1'b0;
            st_r <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - 16'h0001;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // pma_top

// *** design/pma_map.vh ***
// Constants for the program memory access unit.
`ifndef PMA_MAP_VH
`define PMA_MAP_VH
`define PMA_RPAG_MAP_BIT 9
`define PMA_RPAG_WSEL_BIT 8
`define PMA_RPAG_RESET 10'h000
`define PMA_WPAG_RESET 10'h000
`define PMA_TPAG_RESET 8'h00
`define PMA_EA_WIN_BIT 15
`define PMA_ROW_WORDS 64
`define PMA_ROW_IDX_W 6
`define PMA_ROW_BYTES 192
`define PMA_BLOCK_ROWS 8
`define PMA_BLOCK_WORDS 512
`define PMA_BLOCK_BYTES 1536
`define PMA_PEN_MOV 2'h1
`define PMA_PEN_OTHER 2'h2
`define PMA_PEN_REP_EDGE 2'h2
`define PMA_PEN_REP_MID 2'h1
`define PMA_TABLE_WRITE_CYC 2'h2
`define PMA_OP_ROW 4'h1
`define PMA_OP_PAGE_ERASE 4'h2
`define PMA_OP_WORD 4'h3
`define PMA_KEY1 8'h55
`define PMA_KEY2 8'haa
`define PMA_NVM_TIME_US 20
`define PMA_CLK_MHZ 10
`define PMA_NVM_CYC (`PMA_NVM_TIME_US * `PMA_CLK_MHZ)
`define PMA_ERASED 24'hffffff
`endif

// *** design/pma_latch.v ***
// One program-word holding latch of the row buffer.
`timescale 1ns/1ps
module pma_latch (
  input wire clk_sys_i,
  input wire wr_lo_i,
  input wire wr_hi_i,
  input wire [1:0] lo_be_i,
  input wire hi_be_i,
  input wire [15:0] lo_d_i,
  input wire [7:0] hi_d_i,
  output wire [23:0] q_o
);
  // Latches have no reset: they power up unknown, as real holding cells do.
  reg [23:0] word_r;
  always @(posedge clk_sys_i) begin
    if (wr_lo_i && lo_be_i[0]) begin
      word_r[7:0] <= lo_d_i[7:0];
    end
    if (wr_lo_i && lo_be_i[1]) begin
      word_r[15:8] <= lo_d_i[15:8];
    end
    if (wr_hi_i && hi_be_i) begin
      word_r[23:16] <= hi_d_i;
    end
  end
  assign q_o = word_r;
endmodule // pma_latch

// *** bench/pma_array_model.sv ***
// Behavioural program array that answers the unit's read port.
`timescale 1ns/1ps
module pma_array_model (
  input wire clk_sys_i,
  input wire rd_i,
  input wire [22:0] addr_i,
  output logic [23:0] data_o
);
  logic vld_r;
  logic [23:0] word;
  always @(posedge clk_sys_i) begin
    vld_r <= rd_i;
  end
  // Outside a read and the cycle after it the bus shows the inverse, so a sample two or more cycles late cannot pass by luck.
  always @* begin
    word = {addr_i[22:15] ^ 8'h5a, addr_i[15:0] ^ {1'b0, addr_i[22:8]}};
    data_o = (rd_i || vld_r) ? word : ~word;
  end
endmodule // pma_array_model

// *** bench/pma_top_properties.sv ***
// Port-level assertions for the program memory access unit.
`timescale 1ns/1ps
module pma_top_properties #(
  parameter NVM_CYC = 4
) (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire ds_rd_i,
  input wire ds_wr_i,
  input wire [15:0] ds_ea_i,
  input wire ds_is_mov_i,
  input wire ds_in_rep_i,
  input wire ds_rep_edge_i,
  input wire tbl_rd_i,
  input wire tbl_wr_i,
  input wire ctl_we_i,
  input wire [22:0] pm_raddr_o,
  input wire pm_rd_o,
  input wire [15:0] rd_data_o,
  input wire rd_valid_o,
  input wire [1:0] penalty_o,
  input wire addr_trap_o,
  input wire [9:0] rpag_o,
  input wire [9:0] wpag_o,
  input wire [7:0] tpag_o,
  input wire tbl_wr_busy_o,
  input wire ctl_start_o,
  input wire stall_o,
  input wire nvm_prog_o,
  input wire nvm_erase_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_hit;
    ds_rd_i && ds_ea_i[15] && rpag_o[9];
  endsequence
  sequence s_answer;
    pm_rd_o ##1 rd_valid_o;
  endsequence
  a_map_read: assert property (s_hit |=> s_answer) else $error("mapped read not answered");
  a_no_map: assert property (ds_rd_i && !(ds_ea_i[15] && rpag_o[9]) && !tbl_rd_i |=> !pm_rd_o)
    else $error("unmapped read reached array");
  a_addr_form: assert property (s_hit |=> pm_raddr_o == {$past(rpag_o[7:0]), $past(ds_ea_i[14:0])})
    else $error("program address wrong");
  a_upper_zero: assert property (s_hit ##0 rpag_o[8] |=> ##1 rd_data_o[15:8] == 8'h00)
    else $error("phantom byte not zero");
  a_pen_move: assert property (s_hit ##0 !ds_in_rep_i |=> penalty_o == ($past(ds_is_mov_i) ? 2'h1 : 2'h2))
    else $error("penalty outside loop wrong");
  a_pen_repeat: assert property (s_hit ##0 ds_in_rep_i |=> penalty_o == ($past(ds_rep_edge_i) ? 2'h2 : 2'h1))
    else $error("penalty inside loop wrong");
  a_zero_trap: assert property (ds_rd_i && ds_ea_i[15] && rpag_o == 10'h000 |=> addr_trap_o)
    else $error("read trap missing");
  a_write_trap: assert property (ds_wr_i && ds_ea_i[15] && wpag_o == 10'h000 |=> addr_trap_o)
    else $error("write trap missing");
  a_window_ro: assert property (ds_wr_i && !ctl_we_i && !ctl_start_o |=> !nvm_prog_o && !nvm_erase_o)
    else $error("window write reached flash");
  a_tbl_busy: assert property (tbl_wr_i && !tbl_wr_busy_o && !stall_o && !tpag_o[7] |=> tbl_wr_busy_o ##1 !tbl_wr_busy_o)
    else $error("table write not two cycles");
  a_start_stall: assert property (ctl_start_o |-> stall_o) else $error("start without stall");
  a_start_clears: assert property ($rose(ctl_start_o) |-> ##[1:300] !ctl_start_o)
    else $error("start bit never cleared");
endmodule // pma_top_properties

// *** bench/pma_top_tb.sv ***
// Self-checking bench for the program memory access unit.
`timescale 1ns/1ps
module pma_top_tb;
  localparam NVM = 4;
  logic clk_sys_i, resetn_i, rpag_we_i, wpag_we_i, tpag_we_i, ds_rd_i, ds_wr_i, ds_is_mov_i, ds_in_rep_i;
  logic ds_rep_edge_i, tbl_rd_i, tbl_wr_i, tbl_high_i, tbl_byte_i, ctl_we_i, ctl_start_i, ctl_wren_i;
  logic ctl_erase_i, key_we_i, pm_rd_o, rd_valid_o, addr_trap_o, tbl_wr_busy_o, ctl_start_o, ctl_wren_o;
  logic ctl_erase_o, ctl_err_o, stall_o, nvm_prog_o, nvm_erase_o;
  logic [9:0] pag_d_i, rpag_o, wpag_o;
  logic [15:0] ds_ea_i, tbl_ea_i, tbl_d_i, rd_data_o;
  logic [3:0] ctl_op_i, ctl_op_o;
  logic [7:0] key_d_i, tpag_o;
  logic [23:0] pm_rdata_i, tbl_addr_o, nvm_addr_o, nvm_wdata_o, w;
  logic [22:0] pm_raddr_o;
  logic [1:0] penalty_o;
  logic [5:0] nvm_idx_o;
  logic [31:0] r;
  logic [15:0] rq[$];
  logic [29:0] pq[$];
  logic [29:0] e;
  logic [23:0] nb;
  logic hit;
  logic [9:0] pages [0:5] = '{10'h200, 10'h2ff, 10'h300, 10'h3ff, 10'h000, 10'h100};
  logic [15:0] eas [0:3] = '{16'h8000, 16'hffff, 16'h7fff, 16'hc001};
  integer fail_count = 0, checks = 0, seed = 32'h54511522, i, j;
  pma_top #(.NVM_CYC(NVM)) DUT (.*);
  pma_array_model u_arr (.clk_sys_i(clk_sys_i), .rd_i(pm_rd_o), .addr_i(pm_raddr_o), .data_o(pm_rdata_i));
  function automatic [23:0] f(input [22:0] a);
    f = {a[22:15] ^ 8'h5a, a[15:0] ^ {1'b0, a[22:8]}};
  endfunction
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task wrap_up;
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task step;
    @(posedge clk_sys_i);
  endtask
  // Every request is a one-cycle pulse; this drops them on the edge that samples them.
  task idle;
    step;
    {rpag_we_i, wpag_we_i, tpag_we_i, ds_rd_i, ds_wr_i, tbl_rd_i, tbl_wr_i, ctl_we_i, key_we_i} <= 9'h0;
  endtask
  task pg(input [2:0] s, input [9:0] d);
    step;
    {rpag_we_i, wpag_we_i, tpag_we_i} <= s;
    pag_d_i <= d;
    idle;
  endtask
  task rd(input [15:0] a, input wr);
    step;
    r = $random(seed);
    ds_rd_i <= !wr;
    ds_wr_i <= wr;
    ds_ea_i <= a;
    {ds_is_mov_i, ds_in_rep_i, ds_rep_edge_i} <= r[2:0];
    idle;
    #1;
    hit = !wr && a[15] && rpag_o[9];
    chk("pm_rd", pm_rd_o, hit);
    chk("pen", penalty_o, !hit ? 0 : r[1] ? (r[0] ? 2 : 1) : (r[2] ? 1 : 2));
    if (hit) begin
      w = f({rpag_o[7:0], a[14:0]});
      rq.push_back(rpag_o[8] ? {8'h00, w[23:16]} : w[15:0]);
      chk("raddr", pm_raddr_o, {rpag_o[7:0], a[14:0]});
    end
    chk("trap", addr_trap_o, a[15] && (wr ? wpag_o : rpag_o) == 10'h000);
  endtask
  task tw(input [15:0] a, input hi, input by, input [15:0] d);
    step;
    {tbl_wr_i, tbl_high_i, tbl_byte_i, tbl_ea_i, tbl_d_i} <= {1'b1, hi, by, a, d};
    idle;
    #1;
    chk("busy", tbl_wr_busy_o, 1);
    chk("taddr", tbl_addr_o, {tpag_o, a});
  endtask
  task trd(input [15:0] a, input hi, input by);
    step;
    {tbl_rd_i, tbl_high_i, tbl_byte_i, tbl_ea_i} <= {1'b1, hi, by, a};
    idle;
    w = f({tpag_o, a[15:1]});
    if (hi)
      rq.push_back((by && a[0]) ? 16'h0000 : {8'h00, w[23:16]});
    else if (by)
      rq.push_back({8'h00, a[0] ? w[15:8] : w[7:0]});
    else
      rq.push_back(w[15:0]);
  endtask
  // Erase is asked for exactly when the block erase code is chosen.
  task ctl(input s, input [3:0] op);
    step;
    {ctl_we_i, ctl_start_i, ctl_wren_i, ctl_erase_i, ctl_op_i} <= {1'b1, s, 1'b1, op == 4'h2, op};
    idle;
  endtask
  task key(input [7:0] k);
    step;
    key_we_i <= 1'b1;
    key_d_i <= k;
    idle;
  endtask
  task run(input [3:0] op, input ok);
    ctl(1'b0, op);
    #1;
    chk("ctl", {ctl_wren_o, ctl_erase_o, ctl_op_o}, {1'b1, op == 4'h2, op});
    key(8'h55);
    key(8'haa);
    ctl(1'b1, op);
    #1;
    chk("start", {ctl_start_o, stall_o, ctl_err_o}, {ok, ok, !ok});
    if (op == 4'h2)
      chk("erase", {nvm_erase_o, nvm_addr_o}, {1'b1, 24'h125800});
    for (i = 0; i < 300 && ctl_start_o; i++)
      step;
    #1;
    chk("done", {ctl_start_o, stall_o, ctl_err_o}, {2'b00, !ok});
  endtask
  always @(posedge clk_sys_i) begin
    if (rd_valid_o)
      chk("rd_data", rd_data_o, rq.size() ? rq.pop_front() : 16'hxxxx);
    if (nvm_prog_o) begin
      e = pq.size() ? pq.pop_front() : 30'hx;
      chk("commit", {nvm_idx_o, nvm_wdata_o}, e);
      chk("naddr", nvm_addr_o, nb + {e[29:24], 1'b0});
    end
  end
  initial begin
    clk_sys_i = 0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #(5000 * 100);
    fail_count++;
    wrap_up;
  end
  initial begin
    resetn_i = 0;
    {rpag_we_i, wpag_we_i, tpag_we_i, ds_rd_i, ds_wr_i, tbl_rd_i, tbl_wr_i, ctl_we_i, key_we_i} = 9'h0;
    {ds_is_mov_i, ds_in_rep_i, ds_rep_edge_i, tbl_high_i, tbl_byte_i, ctl_start_i, ctl_wren_i, ctl_erase_i} = 8'h0;
    {pag_d_i, ds_ea_i, tbl_ea_i, tbl_d_i, ctl_op_i, key_d_i} = 0;
    repeat (16) step;
    resetn_i <= 1'b1;
    step;
    #1;
    chk("rst", {rpag_o, ctl_start_o, stall_o}, 0);
    // Page corners, unmapped pages and the zero page, each against window corners.
    for (i = 0; i < 6; i++) begin
      pg(3'h4, pages[i]);
      for (j = 0; j < 4; j++)
        rd(eas[j], 1'b0);
    end
    pg(3'h2, 10'h000);
    rd(16'h8000, 1'b1);
    pg(3'h2, 10'h201);
    rd(16'h9000, 1'b1);
    pg(3'h1, 10'h012);
    ctl(1'b0, 4'h1);
    ctl(1'b1, 4'h1);
    repeat (2) step;
    #1;
    chk("locked", {ctl_err_o, ctl_start_o}, 2'b10);
    run(4'h5, 1'b0);
    tw(16'h5a46, 1'b0, 1'b0, 16'h1234);
    run(4'h2, 1'b1);
    tw(16'h000a, 1'b0, 1'b0, 16'hdead);
    // Every latch of the row is loaded, so none programs stale content.
    for (i = 0; i < 64; i++) begin
      r = $random(seed);
      tw({9'h000, i[5:0], 1'b0}, 1'b0, 1'b0, r[15:0]);
      tw({9'h000, i[5:0], 1'b0}, 1'b1, 1'b0, {8'h00, r[23:16]});
      pq.push_back({i[5:0], r[23:0]});
    end
    nb = 24'h120000;
    run(4'h1, 1'b1);
    chk("row", pq.size(), 0);
    // Byte writes build one word on a fresh row; the odd high byte is phantom and refused.
    tw(16'h0105, 1'b0, 1'b1, 16'h00be);
    tw(16'h0105, 1'b1, 1'b1, 16'h0011);
    tw(16'h0104, 1'b0, 1'b1, 16'h00ef);
    tw(16'h0104, 1'b1, 1'b1, 16'h0077);
    pq.push_back({6'd2, 24'h77beef});
    nb = 24'h120100;
    run(4'h3, 1'b1);
    chk("word", pq.size(), 0);
    for (j = 0; j < 16; j++) begin
      r = $random(seed);
      trd(r[15:0], r[16], r[17]);
    end
    repeat (4) step;
    chk("reads", rq.size(), 0);
    wrap_up;
  end
endmodule // pma_top_tb
bind pma_top pma_top_properties #(.NVM_CYC(NVM_CYC)) u_props (.*);
